// ==== hw/ccc_pkg.sv ====
// Package: register map, field layout and reset values of the conversion control block
package ccc_pkg;
   // Printed offsets are not word multiples, so they are indices
   localparam logic [7:0]  IDX_ONE_SHOT   = 8'h01;
   localparam logic [7:0]  IDX_RANGE      = 8'h02;
   localparam logic [7:0]  IDX_POWER      = 8'h03;
   localparam logic [7:0]  IDX_STATUS     = 8'h04;
   localparam logic [7:0]  IDX_CONV_TIME  = 8'h05;
   localparam logic [9:0]  ADDR_ONE_SHOT  = {IDX_ONE_SHOT, 2'b00};
   localparam logic [9:0]  ADDR_RANGE     = {IDX_RANGE, 2'b00};
   localparam logic [9:0]  ADDR_POWER     = {IDX_POWER, 2'b00};
   localparam logic [9:0]  ADDR_STATUS    = {IDX_STATUS, 2'b00};
   localparam logic [9:0]  ADDR_CONV_TIME = {IDX_CONV_TIME, 2'b00};
   // Field positions
   localparam int          TRIG_BIT       = 0;
   localparam int          MODE_BIT       = 1;
   localparam int          CH1_LO         = 0;
   localparam int          CH2_LO         = 4;
   localparam int          PD1_BIT        = 1;
   localparam int          PD2_BIT        = 2;
   // Reset values and masks
   localparam logic [7:0]  ONE_SHOT_RST   = 8'h02;
   localparam logic [7:0]  RANGE_RST      = 8'h00;
   localparam logic [7:0]  POWER_RST      = 8'h00;
   localparam logic [7:0]  ONE_SHOT_MASK  = 8'h03;
   localparam logic [7:0]  RANGE_MASK     = 8'h33;
   localparam logic [7:0]  POWER_MASK     = 8'h06;
   localparam logic [15:0] CONV_TIME_RST  = 16'h0020;
   // Full-scale selections
   typedef enum logic [2:0] {
      CCC_FS_5PF  = 3'b001,
      CCC_FS_10PF = 3'b010,
      CCC_FS_20PF = 3'b100
   } ccc_fs_t;
   // Decode of a 2-bit range code
   function automatic ccc_fs_t ccc_fs_decode(input logic [1:0] code);
      ccc_fs_t r;
      r = (code == 2'b00) ? CCC_FS_5PF :
          (code == 2'b01) ? CCC_FS_10PF : CCC_FS_20PF;
      return r;
   endfunction
endpackage

// ==== hw/ccc_cfg_if.sv ====
// Interface: configuration and event wires between register file and sequencer
`timescale 1ns/100ps
interface ccc_cfg_if;
   logic        start;
   logic        busy;
   logic        done;
   logic [1:0]  ch_en;
   logic [15:0] conv_cycles;
   modport regs (output start, output ch_en, output conv_cycles,
                 input busy, input done);
   modport seq  (input start, input ch_en, input conv_cycles,
                 output busy, output done);
endinterface

// ==== hw/ccc_seq.sv ====
// Conversion sequencer: times one single-shot conversion of enabled channels
`timescale 1ns/100ps
module ccc_seq (
   input  wire logic hclk,
   input  wire logic hresetn,
   ccc_cfg_if.seq    cfg
);
   typedef enum logic [1:0] {
      CCC_IDLE = 2'b01,
      CCC_CONV = 2'b10
   } ccc_state_t;

   ccc_state_t  state_r;
   logic [15:0] cnt_r;
   logic        last_w;

   assign last_w   = (cnt_r <= 16'h0001);
   assign cfg.busy = (state_r == CCC_CONV);

   ////////////////////////////////////////////////////////////////////////
   // Counts the conversion time; done pulses in the cycle after the last busy cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r  <= CCC_IDLE;
         cnt_r    <= 16'h0000;
         cfg.done <= 1'b0;
      end else begin
         cfg.done <= 1'b0;
         unique case (state_r)
            CCC_IDLE: begin
               if (cfg.start) begin
                  state_r <= CCC_CONV;
                  cnt_r   <= cfg.conv_cycles;
               end
            end
            CCC_CONV: begin
               cnt_r <= cnt_r - 16'h0001;
               if (last_w) begin
                  state_r  <= CCC_IDLE;
                  cfg.done <= 1'b1;
               end
            end
         endcase
      end
   end

   conv_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg.start && state_r == CCC_IDLE && cfg.conv_cycles == 16'h0002
      |=> cfg.busy ##1 cfg.busy ##1 cfg.done) // see (RULE4)
      else $error("conversion length wrong");
endmodule

// ==== hw/ccc_top.sv ====
// Top: AHB-Lite register file for single-shot conversion and range control
//
// Contract
// (RULE1) Every reset loads the one-shot register with 02h.
// (RULE2) Trigger write of 1 in enabled mode converts all powered-up channels.
// (RULE3) Writes to the trigger bit are ignored while it holds 1.
// (RULE4) Trigger bit clears itself when the conversion ends.
// (RULE5) Bit 1 of the one-shot register enables single conversion mode.
// (RULE6) One-shot bits 7..2 and range bits 3..2 read as zero.
// (RULE7) Channel 1 range bits 1..0: 00 5pF, 01 10pF, else 20pF.
// (RULE8) Channel 2 has its own independent 2-bit range field.
// (RULE9) Channel 2 range in bits 5..4, same coding as channel 1.
// (RULE10) A channel converts only while its power-down bit is 0; the code samples the bits at start, so a later power-down does not stop it.
// (RULE11) Each new result sets the channel's ready flag until software clears.
// (RULE12) Trigger writes do nothing while single conversion mode is off; the code takes the mode bit from the same write, so 03h starts one.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
module ccc_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [2:0]  ch1_fs_sel,
   output logic      [2:0]  ch2_fs_sel,
   output logic      [1:0]  ch_converting,
   output logic      [1:0]  ch1_result_ready_flag
);
   ccc_cfg_if cfg ();

   logic [7:0]  one_shot_r;
   logic [7:0]  range_r;
   logic [7:0]  power_r;
   logic [1:0]  ready_r;
   logic [15:0] conv_time_r;
   logic [1:0]  conv_ch_r;
   logic        wr_pend_r;
   logic [9:0]  wr_addr_r;
   logic [31:0] rdata_nxt;
   logic        addr_ok;
   logic        wr_one_shot;
   logic        wr_range;
   logic        wr_power;
   logic        wr_status;
   logic        wr_time;
   logic        trig_req;
   logic        start_w;
   logic [1:0]  ch_en_w;

   ////////////////////////////////////////////////////////////////////////
   // Address phase capture; the slave never inserts wait states
   assign addr_ok = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 10'h000;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         wr_addr_r <= haddr[9:0];
      end
   end

   // Write strobes decoded in the data phase
   assign wr_one_shot = wr_pend_r && (wr_addr_r == ccc_pkg::ADDR_ONE_SHOT);
   assign wr_range    = wr_pend_r && (wr_addr_r == ccc_pkg::ADDR_RANGE);
   assign wr_power    = wr_pend_r && (wr_addr_r == ccc_pkg::ADDR_POWER);
   assign wr_status   = wr_pend_r && (wr_addr_r == ccc_pkg::ADDR_STATUS);
   assign wr_time     = wr_pend_r && (wr_addr_r == ccc_pkg::ADDR_CONV_TIME);

   ////////////////////////////////////////////////////////////////////////
   // Trigger accepted only when idle, mode enabled and a channel is up
   assign ch_en_w  = ~{power_r[ccc_pkg::PD2_BIT],
                       power_r[ccc_pkg::PD1_BIT]};           // see (RULE10)
   assign trig_req = wr_one_shot && hwdata[ccc_pkg::TRIG_BIT]
                     && !one_shot_r[ccc_pkg::TRIG_BIT];      // see (RULE3)
   // Mode bit as it stands after this write, so enable+trigger works
   assign start_w  = trig_req && hwdata[ccc_pkg::MODE_BIT]
                     && (ch_en_w != 2'b00);           // see (RULE2) (RULE12)
   assign cfg.start       = start_w;
   assign cfg.ch_en       = ch_en_w;
   assign cfg.conv_cycles = conv_time_r;

   ccc_seq u_seq (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cfg     (cfg)
   );

   ////////////////////////////////////////////////////////////////////////
   // One-shot register: trigger is hardware owned while set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         one_shot_r <= ccc_pkg::ONE_SHOT_RST;                 // see (RULE1)
      end else begin
         if (wr_one_shot) begin
            one_shot_r[ccc_pkg::MODE_BIT] <= hwdata[ccc_pkg::MODE_BIT]; // see (RULE5)
         end
         if (cfg.done) begin
            one_shot_r[ccc_pkg::TRIG_BIT] <= 1'b0;            // see (RULE4)
         end else if (start_w) begin
            one_shot_r[ccc_pkg::TRIG_BIT] <= 1'b1;            // see (RULE2)
         end
      end
   end

   // Range, power-down and conversion-time registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         range_r     <= ccc_pkg::RANGE_RST;
         power_r     <= ccc_pkg::POWER_RST;
         conv_time_r <= ccc_pkg::CONV_TIME_RST;
      end else begin
         if (wr_range)
            range_r <= hwdata[7:0] & ccc_pkg::RANGE_MASK;     // see (RULE8)
         if (wr_power)
            power_r <= hwdata[7:0] & ccc_pkg::POWER_MASK;     // see (RULE10)
         if (wr_time)
            conv_time_r <= hwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channels latched at start; ready flags set wins over a clear by write 1
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_ch_r <= 2'b00;
         ready_r   <= 2'b00;
      end else begin
         if (start_w)
            conv_ch_r <= ch_en_w;
         else if (cfg.done)
            conv_ch_r <= 2'b00;
         ready_r <= (ready_r & ~(wr_status ? hwdata[1:0] : 2'b00))
                    | (cfg.done ? conv_ch_r : 2'b00);       // see (RULE11)
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; reserved bits masked to zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (haddr[9:0])
         ccc_pkg::ADDR_ONE_SHOT:
            rdata_nxt[7:0] = one_shot_r & ccc_pkg::ONE_SHOT_MASK; // see (RULE6)
         ccc_pkg::ADDR_RANGE:
            rdata_nxt[7:0] = range_r & ccc_pkg::RANGE_MASK;       // see (RULE6)
         ccc_pkg::ADDR_POWER:
            rdata_nxt[7:0] = power_r;
         ccc_pkg::ADDR_STATUS:
            rdata_nxt[1:0] = ready_r;
         ccc_pkg::ADDR_CONV_TIME:
            rdata_nxt[15:0] = conv_time_r;
         default:
            rdata_nxt = 32'h0000_0000;
      endcase
   end

   // All outputs registered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata                <= 32'h0000_0000;
         hreadyout             <= 1'b1;
         hresp                 <= 1'b0;
         ch1_fs_sel            <= 3'b001;
         ch2_fs_sel            <= 3'b001;
         ch_converting         <= 2'b00;
         ch1_result_ready_flag <= 2'b00;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addr_ok && !hwrite)
            hrdata <= rdata_nxt;
         ch1_fs_sel <= ccc_pkg::ccc_fs_decode(
                          range_r[ccc_pkg::CH1_LO +: 2]);     // see (RULE7)
         ch2_fs_sel <= ccc_pkg::ccc_fs_decode(
                          range_r[ccc_pkg::CH2_LO +: 2]);     // see (RULE9)
         ch_converting         <= conv_ch_r;
         ch1_result_ready_flag <= ready_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence trig_write_s;
      wr_one_shot && hwdata[ccc_pkg::TRIG_BIT];
   endsequence

   reset_val_a: assert property (@(posedge hclk)
      $rose(hresetn) |-> one_shot_r == 8'h02) // see (RULE1)
      else $error("one-shot reset value wrong");
   trig_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
      trig_write_s and hwdata[ccc_pkg::MODE_BIT] && ch_en_w != 2'b00
      && !one_shot_r[0] |=> one_shot_r[0] && cfg.busy) // see (RULE2)
      else $error("trigger did not start conversion");
   trig_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn)
      one_shot_r[0] && !cfg.done |=> one_shot_r[0]) // see (RULE3)
      else $error("trigger changed while busy");
   trig_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg.done |=> !one_shot_r[0]
      && ((ready_r & $past(conv_ch_r)) == $past(conv_ch_r))) // see (RULE4)
      else $error("trigger not cleared at end");
   mode_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      trig_write_s and !hwdata[ccc_pkg::MODE_BIT] && !one_shot_r[0]
      |=> !one_shot_r[0] && !cfg.busy) // see (RULE12)
      else $error("conversion started with mode off");
   rsvd_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (one_shot_r[7:2] == 6'h00) && (range_r[3:2] == 2'b00)) // see (RULE6)
      else $error("reserved bits not zero");
   ch1_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
      range_r[1:0] == 2'b01 ##1 range_r[1:0] == 2'b01
      |-> ch1_fs_sel == 3'b010) // see (RULE7)
      else $error("channel 1 range decode wrong");
   ch2_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
      range_r[5] ##1 range_r[5] |-> ch2_fs_sel == 3'b100) // see (RULE9)
      else $error("channel 2 range decode wrong");
   pd_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      start_w |=> conv_ch_r == ~$past({power_r[2], power_r[1]})) // see (RULE10)
      else $error("powered-down channel converted");
   ready_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ready_r[0] && !(wr_status && hwdata[0]) |=> ready_r[0]) // see (RULE11)
      else $error("ready flag lost");
endmodule

// ==== verif/cdc_conversion_control_tb.sv ====
// Testbench: register and conversion checks of the conversion control block
`timescale 1ns/100ps
module cdc_conversion_control_tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [2:0]  ch1_fs_sel;
   logic [2:0]  ch2_fs_sel;
   logic [1:0]  ch_converting;
   logic [1:0]  rdy;
   logic [31:0] rd;
   int          error_cnt;
   int          num_checks;
   int          cyc;

   // Single slave, so its ready is the bus ready
   ccc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ch1_fs_sel(ch1_fs_sel),
      .ch2_fs_sel(ch2_fs_sel), .ch_converting(ch_converting),
      .ch1_result_ready_flag(rdy));

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; ceiling is far above the few hundred cycles used
   initial hclk = 1'b0;
   always #10 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, seen,
                  exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // One AHB-Lite single word transfer; waits on ready in both phases
   task automatic xfer(input logic [9:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {22'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      xfer(a, 1'b1, d, dummy);
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp,
                         input string msg);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h0, r);
      check(r, exp, msg);
   endtask

   // Expected one-hot full scale for a 2-bit code
   function automatic logic [2:0] fs_exp(input logic [1:0] c);
      return (c == 2'b00) ? 3'h1 : (c == 2'b01) ? 3'h2 : 3'h4;
   endfunction

   // Waits, bounded, until no channel converts
   task automatic wait_idle();
      int n;
      n = 0;
      while (ch_converting !== 2'b00 && n < 200) begin
         @(posedge hclk);
         n++;
      end
      check({31'h0, n < 200}, 32'h1, "conversion never ended");
      repeat (2) @(posedge hclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      check({29'h0, ch1_fs_sel}, 32'h1, "ch1 reset range");
      check({31'h0, hresp}, 32'h0, "response not okay");
      check({31'h0, hreadyout}, 32'h1, "ready not high");
      check({29'h0, ch2_fs_sel}, 32'h1, "ch2 reset range");
      rd_chk(ccc_pkg::ADDR_ONE_SHOT, 32'h2, "one-shot reset");
      rd_chk(ccc_pkg::ADDR_RANGE, 32'h0, "range reset");
      rd_chk(10'h3c, 32'h0, "unmapped read");
      $display("test reset done");
   endtask

   task automatic t_range();
      logic [1:0] c1;
      logic [1:0] c2;
      for (int i = 0; i < 4; i++) begin
         c2 = i[1:0];
         c1 = 2'h3 - i[1:0];
         wr(ccc_pkg::ADDR_RANGE, {26'h0, c2, 2'h3, c1});
         repeat (2) @(posedge hclk);
         check({29'h0, ch1_fs_sel}, {29'h0, fs_exp(c1)}, "ch1 scale");
         check({29'h0, ch2_fs_sel}, {29'h0, fs_exp(c2)}, "ch2 scale");
         rd_chk(ccc_pkg::ADDR_RANGE, {26'h0, c2, 2'h0, c1}, "range rb");
      end
      wr(ccc_pkg::ADDR_ONE_SHOT, 32'hfc);
      rd_chk(ccc_pkg::ADDR_ONE_SHOT, 32'h0, "one-shot reserved");
      $display("test range done");
   endtask

   // Trigger with the given power-down setting and check who converts
   task automatic t_conv(input logic [1:0] pd);
      logic [1:0] en;
      en = ~pd;
      wr(ccc_pkg::ADDR_POWER, {29'h0, pd, 1'b0});
      wr(ccc_pkg::ADDR_ONE_SHOT, 32'h3);
      repeat (2) @(posedge hclk);
      check({30'h0, ch_converting}, {30'h0, en}, "converting set");
      wr(ccc_pkg::ADDR_ONE_SHOT, 32'h2);
      rd_chk(ccc_pkg::ADDR_ONE_SHOT, 32'h3, "trigger held");
      wait_idle();
      rd_chk(ccc_pkg::ADDR_ONE_SHOT, 32'h2, "trigger self clear");
      rd_chk(ccc_pkg::ADDR_STATUS, {30'h0, en}, "ready status");
      check({30'h0, rdy}, {30'h0, en}, "ready flag pins");
      repeat (4) @(posedge hclk);
      check({30'h0, rdy}, {30'h0, en}, "ready flag held");
      wr(ccc_pkg::ADDR_STATUS, 32'h3);
      rd_chk(ccc_pkg::ADDR_STATUS, 32'h0, "ready cleared");
      $display("test conversion pd=%b done", pd);
   endtask

   task automatic t_mode_off();
      wr(ccc_pkg::ADDR_ONE_SHOT, 32'h1);
      repeat (4) @(posedge hclk);
      check({30'h0, ch_converting}, 32'h0, "start while disabled");
      rd_chk(ccc_pkg::ADDR_ONE_SHOT, 32'h0, "mode off readback");
      wr(ccc_pkg::ADDR_ONE_SHOT, 32'h2);
      rd_chk(ccc_pkg::ADDR_ONE_SHOT, 32'h2, "mode on readback");
      $display("test mode off done");
   endtask

   // Two-cycle conversion, both channels up; trigger gone in 3 edges
   task automatic t_short();
      wr(ccc_pkg::ADDR_POWER, 32'h0);
      wr(ccc_pkg::ADDR_CONV_TIME, 32'h2);
      wr(ccc_pkg::ADDR_ONE_SHOT, 32'h3);
      repeat (4) @(posedge hclk);
      rd_chk(ccc_pkg::ADDR_ONE_SHOT, 32'h2, "short self clear");
      rd_chk(ccc_pkg::ADDR_STATUS, 32'h3, "short ready");
      wr(ccc_pkg::ADDR_STATUS, 32'h3);
      $display("test short conversion done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0;
      htrans  = 2'b00;
      hwrite  = 1'b0;
      hsize   = 3'b010;
      hwdata  = 32'h0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_range();
      wr(ccc_pkg::ADDR_ONE_SHOT, 32'h2);
      // Long enough that reads land mid-conversion
      wr(ccc_pkg::ADDR_CONV_TIME, 32'h10);
      t_conv(2'b00);
      t_conv(2'b01);
      t_conv(2'b10);
      t_mode_off();
      t_short();
      end_of_test();
   end
endmodule
